// File: dv/aco_ctrl_tb.sv
// self-checking bench for the current-output channel control
`timescale 1ns/1ps
module aco_ctrl_tb;
    import aco_pkg::*;
    logic clk, rst_n, word_wr, word_sel, comm_lost, period_wr, fb_wr, fb_sel, fb_hold, act_short;
    logic [15:0] word_data, fb_value, word_1, word_2, status_1, status_2;
    logic [7:0] period_data, period;
    logic [11:0] code_1, code_2;
    logic load_1, load_2;
    int num_errors = 0;
    int total_checks = 0;
    aco_ctrl #(.CYC_PER_MS(4)) dut (.CLK(clk), .RST_N(rst_n), .WORD_WR(word_wr), .WORD_SEL(word_sel),
        .WORD_DATA(word_data), .PERIOD_WR(period_wr), .PERIOD_DATA(period_data), .FB_WR(fb_wr),
        .FB_SEL(fb_sel), .FB_HOLD(fb_hold), .FB_VALUE(fb_value), .COMM_LOST(comm_lost),
        .ACT_SHORT(act_short), .PERIOD(period), .WORD_1(word_1), .WORD_2(word_2), .CODE_1(code_1),
        .CODE_2(code_2), .LOAD_1(load_1), .LOAD_2(load_2), .STATUS_1(status_1), .STATUS_2(status_2));
    aco_link_model link (.CLK(clk), .WORD_WR(word_wr), .WORD_SEL(word_sel), .WORD_DATA(word_data),
        .COMM_LOST(comm_lost));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_flag(input logic got, input logic exp);
        check_val({15'h0000, got}, {15'h0000, exp});
    endtask : check_flag
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    function automatic logic [15:0] exp_status(input logic [15:0] w);
        logic [15:0] c;
        c = w[SIGN_BIT] ? ZERO_WORD : {1'b0, w[MAG_HI:MAG_LO], 3'b000};
        exp_status = ZERO_WORD;
        exp_status[ST_OVER_WARN] = c > FULL_SCALE_COUNT;
        exp_status[ST_OVER_ERR] = c >= OVER_ERR_COUNT;
        exp_status[ST_UNDER_WARN] = c < UNDER_WARN_COUNT;
        exp_status[ST_UNDER_ERR] = c == ZERO_WORD;
    endfunction : exp_status
    task automatic test_reset();
        tick(1);
        check_val({8'h00, period}, 16'h000a);
        check_val(status_1, 16'h0030);
        check_val({4'h0, code_2}, 16'h0000);
    endtask : test_reset
    task automatic test_words();
        logic [15:0] w [7] = '{16'h0023, 16'h7d00, 16'h7d08, 16'h7ff8, 16'h8000, 16'h0300, 16'h02f8};
        for (int i = 0; i < 7; i++) begin
            link.send_word(i[0], w[i]);
            check_val({4'h0, i[0] ? code_2 : code_1}, w[i][15] ? 16'h0000 : {4'h0, w[i][14:3]});
            check_flag(i[0] ? load_2 : load_1, 1'b1);
            tick(1);
            // load pulse is gone by now, the status has just settled
            check_val(i[0] ? status_2 : status_1, exp_status(w[i]));
        end
        link.send_pair(16'h0100, 16'h0200);
        tick(2);
        check_val({code_2, code_1[3:0]}, 16'h0400);
        check_val(word_1 ^ word_2, 16'h0300);
    endtask : test_words
    task automatic test_period();
        logic [7:0] d [5] = '{8'h03, 8'h05, 8'hff, 8'h04, 8'h05};
        logic [7:0] e [5] = '{8'h0a, 8'h05, 8'hff, 8'hff, 8'h05};
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            period_wr = 1'b1;
            period_data = d[i];
            @(negedge clk);
            period_wr = 1'b0;
            check_val({8'h00, period}, {8'h00, e[i]});
        end
    endtask : test_period
    task automatic test_refresh();
        int n;
        link.send_word(1'b0, 16'h1000);
        tick(1);
        n = 0;
        tick(1);
        while (load_1 !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check_flag(n >= 17 && n <= 22, 1'b1);
        check_flag(load_2, 1'b1);
    endtask : test_refresh
    task automatic fb_write(input logic sel, input logic hold, input logic [15:0] v);
        @(negedge clk);
        {fb_wr, fb_sel, fb_hold, fb_value} = {1'b1, sel, hold, v};
        @(negedge clk);
        fb_wr = 1'b0;
        fb_value = ~v;
    endtask : fb_write
    task automatic test_fallback();
        link.send_pair(16'h7d00, 16'h2000);
        link.set_link(1'b1);
        tick(3);
        check_val({code_1, code_2[3:0]}, 16'h0000);
        link.set_link(1'b0);
        tick(3);
        check_val({4'h0, code_1}, 16'h0fa0);
        fb_write(1'b0, 1'b0, 16'h1234);
        fb_write(1'b1, 1'b1, 16'h4000);
        link.set_link(1'b1);
        tick(3);
        check_val({4'h0, code_1}, 16'h0246);
        check_val({4'h0, code_2}, 16'h0400);
        link.send_word(1'b0, 16'h0800);
        tick(2);
        check_val(word_1, 16'h0800);
        check_val({4'h0, code_1}, 16'h0246);
        link.set_link(1'b0);
        tick(3);
        check_val({4'h0, code_1}, 16'h0100);
        fb_write(1'b0, 1'b0, 16'h7d08);
        link.set_link(1'b1);
        tick(3);
        check_val({4'h0, code_1}, 16'h0246);
        link.set_link(1'b0);
        tick(3);
    endtask : test_fallback
    task automatic test_short();
        link.send_word(1'b0, 16'h7ff8);
        act_short = 1'b1;
        tick(4);
        check_val(status_1, 16'h000f);
        act_short = 1'b0;
        tick(4);
        check_val(status_1, 16'h000c);
    endtask : test_short
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // whole run takes well under 2000 cycles
    initial begin
        #100us;
        num_errors++;
        stop_test();
    end
    initial begin
        {rst_n, period_wr, fb_wr, fb_sel, fb_hold, act_short} = 6'h00;
        period_data = 8'h00;
        fb_value = 16'h0000;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_words();
        test_period();
        test_refresh();
        test_fallback();
        test_short();
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        test_reset();
        stop_test();
    end
endmodule : aco_ctrl_tb

// File: dv/aco_link_model.sv
// far-side link model: writes channel words and reports link loss
`timescale 1ns/1ps
module aco_link_model (
    input wire logic CLK,
    output logic WORD_WR,
    output logic WORD_SEL,
    output logic [15:0] WORD_DATA,
    output logic COMM_LOST
);
    initial begin
        WORD_WR = 1'b0;
        WORD_SEL = 1'b0;
        WORD_DATA = 16'h0000;
        COMM_LOST = 1'b0;
    end
    task automatic put(input logic sel, input logic [15:0] data);
        @(negedge CLK);
        WORD_WR = 1'b1;
        WORD_SEL = sel;
        WORD_DATA = data;
    endtask : put
    // released data shows the inverse so a stale word cannot pass
    task automatic release_bus();
        @(negedge CLK);
        WORD_WR = 1'b0;
        WORD_DATA = ~WORD_DATA;
    endtask : release_bus
    task automatic send_word(input logic sel, input logic [15:0] data);
        put(sel, data);
        release_bus();
    endtask : send_word
    task automatic send_pair(input logic [15:0] w1, input logic [15:0] w2);
        put(1'b0, w1);
        put(1'b1, w2);
        release_bus();
    endtask : send_pair
    task automatic set_link(input logic lost);
        @(negedge CLK);
        COMM_LOST = lost;
    endtask : set_link
endmodule : aco_link_model

// File: logic/aco_ctrl.sv
// two-channel current-output control: scaling, status, refresh and fallback
//
// Operation
// - refresh period is an 8-bit millisecond value; only 5 to 255 accepted.
// - a single refresh period serves both channels.
// - on lost communication every channel goes to fallback until it returns.
// - per-channel fallback mode: predefined value, or hold the last output.
// - after reset both channels use predefined-value fallback.
// - predefined fallback value spans 0 to 32000 counts, 0 to 20 mA.
// - after reset both predefined fallback values are zero.
// - in hold mode the stored predefined value is ignored.
// - values resolve to 12 bits; low three bits truncate to a multiple of 8.
// - a negative command drives zero output and raises under-current error.
// - bit 15 is the sign, bits 14 to 3 magnitude, low three ignored.
// - 32000 counts is 20 mA; over-current warning above 32000.
// - over-current error when the count reaches 32760.
// - under-current warning below 768; under-current error at zero.
// - output current scales linearly at 1600 counts per milliampere.
// - outputs follow master data; the block builds each channel status word.
// - without new data for one period the held value is re-applied.
// - status bits 0 to 5: global, short, over warn, over error, under warn, under error.
// - only a supply short sets the global bit, never current faults.
`timescale 1ns/1ps
module aco_ctrl
    import aco_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
    parameter logic [7:0] DEF_PERIOD = 8'h0a
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WORD_WR,
    input wire logic WORD_SEL,
    input wire logic [15:0] WORD_DATA,
    input wire logic PERIOD_WR,
    input wire logic [7:0] PERIOD_DATA,
    input wire logic FB_WR,
    input wire logic FB_SEL,
    input wire logic FB_HOLD,
    input wire logic [15:0] FB_VALUE,
    input wire logic COMM_LOST,
    input wire logic ACT_SHORT,
    output logic [7:0] PERIOD,
    output logic [15:0] WORD_1,
    output logic [15:0] WORD_2,
    output logic [11:0] CODE_1,
    output logic [11:0] CODE_2,
    output logic LOAD_1,
    output logic LOAD_2,
    output logic [15:0] STATUS_1,
    output logic [15:0] STATUS_2
);
    localparam int MSW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
    localparam logic [MSW-1:0] MS_LAST = MSW'(CYC_PER_MS - 1);
    localparam logic [MSW-1:0] MS_ZERO = '0;
    localparam logic [11:0] FULL_CODE = 12'(FULL_SCALE_COUNT >> MAG_LO);

    // count seen by the status logic; negative commands count as zero
    function automatic logic [15:0] aco_count(input logic [15:0] w);
        aco_count = w[SIGN_BIT] ? ZERO_WORD : {1'b0, w[MAG_HI:MAG_LO], 3'b000};
    endfunction : aco_count

    function automatic logic [15:0] aco_status(input logic [15:0] w, input logic short);
        logic [15:0] c;
        logic [15:0] s;
        c = aco_count(w);
        s = ZERO_WORD;
        s[ST_SHORT] = short;
        s[ST_GLOBAL] = short;
        s[ST_OVER_WARN] = (c > FULL_SCALE_COUNT);
        s[ST_OVER_ERR] = (c >= OVER_ERR_COUNT);
        s[ST_UNDER_WARN] = (c < UNDER_WARN_COUNT);
        s[ST_UNDER_ERR] = (c == ZERO_WORD);
        aco_status = s;
    endfunction : aco_status

    logic short_s1;
    logic short_s2;
    logic comm_q;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [7:0] per_cnt;
    logic refresh;
    logic [15:0] word [CHANNELS];
    logic fb_hold [CHANNELS];
    logic [15:0] fb_val [CHANNELS];
    logic [15:0] app [CHANNELS];
    logic [11:0] code [CHANNELS];
    logic load_q [CHANNELS];
    logic [15:0] stat [CHANNELS];
    logic [15:0] src [CHANNELS];
    logic load [CHANNELS];
    logic comm_edge;

    // actuator short comes from the supply monitor, another domain
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            short_s1 <= 1'b0;
            short_s2 <= 1'b0;
        end else begin
            short_s1 <= ACT_SHORT;
            short_s2 <= short_s1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            comm_q <= 1'b0;
        end else begin
            comm_q <= COMM_LOST;
        end
    end

    assign comm_edge = COMM_LOST ^ comm_q;

    // out-of-range period writes are dropped, the old period stays
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PERIOD <= DEF_PERIOD;
        end else if (PERIOD_WR && PERIOD_DATA >= PERIOD_MIN) begin
            PERIOD <= PERIOD_DATA;
        end
    end

    // millisecond prescaler restarts with each data word so the period is exact
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_cnt <= MS_ZERO;
        end else if (WORD_WR || ms_tick) begin
            ms_cnt <= MS_ZERO;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end

    assign ms_tick = (ms_cnt == MS_LAST);

    // one shared period counter for both channels
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            per_cnt <= PERIOD_ZERO;
        end else if (WORD_WR || refresh) begin
            per_cnt <= PERIOD_ZERO;
        end else if (ms_tick) begin
            per_cnt <= per_cnt + PERIOD_ONE;
        end
    end

    assign refresh = ms_tick && (per_cnt >= PERIOD - PERIOD_ONE);

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            // channel index follows WORD_SEL, not word order: WORD_SEL zero is channel one
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    word[gi] <= ZERO_WORD;
                end else if (WORD_WR && WORD_SEL == 1'(gi)) begin
                    word[gi] <= WORD_DATA;
                end
            end

            // values above full scale are refused; negatives kept and read as zero
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    fb_hold[gi] <= 1'b0;
                    fb_val[gi] <= ZERO_WORD;
                end else if (FB_WR && FB_SEL == 1'(gi)) begin
                    fb_hold[gi] <= FB_HOLD;
                    if (FB_VALUE[SIGN_BIT] || FB_VALUE <= FULL_SCALE_COUNT) begin
                        fb_val[gi] <= FB_VALUE;
                    end
                end
            end

            always_comb begin
                if (COMM_LOST) begin
                    src[gi] = fb_hold[gi] ? app[gi] : fb_val[gi];
                end else if (WORD_WR && WORD_SEL == 1'(gi)) begin
                    // a fresh word goes out in the cycle it arrives, not one later
                    src[gi] = WORD_DATA;
                end else begin
                    src[gi] = word[gi];
                end
            end

            // data written while the link is down is kept for its return
            assign load[gi] = (WORD_WR && WORD_SEL == 1'(gi) && !COMM_LOST) || refresh || comm_edge;

            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    app[gi] <= ZERO_WORD;
                    code[gi] <= ZERO_CODE;
                end else if (load[gi]) begin
                    app[gi] <= src[gi];
                    // truncation to a multiple of 8 falls out of dropping bits 2..0
                    code[gi] <= src[gi][SIGN_BIT] ? ZERO_CODE : src[gi][MAG_HI:MAG_LO];
                end
            end

            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    load_q[gi] <= 1'b0;
                end else begin
                    load_q[gi] <= load[gi];
                end
            end

            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    stat[gi] <= ZERO_WORD;
                end else begin
                    stat[gi] <= aco_status(app[gi], short_s2);
                end
            end
        end
    endgenerate

    assign WORD_1 = word[0];
    assign WORD_2 = word[1];
    assign CODE_1 = code[0];
    assign CODE_2 = code[1];
    assign LOAD_1 = load_q[0];
    assign LOAD_2 = load_q[1];
    assign STATUS_1 = stat[0];
    assign STATUS_2 = stat[1];

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_neg_load;
        load[0] && src[0][SIGN_BIT];
    endsequence

    sequence s_lost_predef;
        COMM_LOST && !fb_hold[0] && load[0];
    endsequence

    sequence s_comm_back;
        !COMM_LOST && comm_q && !WORD_WR;
    endsequence

    sequence s_short_up;
        $rose(short_s2);
    endsequence

    a_period_low_drop: assert property (PERIOD_WR && PERIOD_DATA < PERIOD_MIN |=> $stable(PERIOD))
        else $error("period accepted below minimum");
    a_period_take: assert property (PERIOD_WR && PERIOD_DATA >= PERIOD_MIN |=> PERIOD == $past(PERIOD_DATA))
        else $error("valid period not taken");
    a_scale_full: assert property (load[0] && src[0] == FULL_SCALE_COUNT |=> code[0] == FULL_CODE)
        else $error("full scale count wrong");
    a_fallback_predef: assert property (s_lost_predef |=> app[0] == $past(fb_val[0]))
        else $error("predefined fallback not applied");
    a_fallback_hold: assert property (COMM_LOST && fb_hold[1] |=> $stable(app[1]) && $stable(code[1]))
        else $error("hold fallback changed output");
    a_neg_zero: assert property (s_neg_load |=> code[0] == ZERO_CODE ##1 stat[0][ST_UNDER_ERR])
        else $error("negative command not zeroed");
    a_code_trunc: assert property (load[1] && !src[1][SIGN_BIT] |=> code[1] == $past(src[1][MAG_HI:MAG_LO]))
        else $error("code not truncated from magnitude");
    a_over_warn: assert property (aco_count(app[0]) > FULL_SCALE_COUNT |=> stat[0][ST_OVER_WARN])
        else $error("over-current warning missing");
    a_over_err: assert property (aco_count(app[0]) == OVER_ERR_COUNT
        |=> stat[0][ST_OVER_ERR] && stat[0][ST_OVER_WARN])
        else $error("over-current error missing");
    a_under_warn: assert property (aco_count(app[1]) >= UNDER_WARN_COUNT
        |=> !stat[1][ST_UNDER_WARN] && !stat[1][ST_UNDER_ERR])
        else $error("under-current flag wrongly set");
    a_global_short: assert property (stat[0][ST_GLOBAL] == stat[0][ST_SHORT])
        else $error("global bit not tied to short");
    a_refresh_time: assert property (refresh |-> ms_tick && per_cnt == PERIOD - PERIOD_ONE)
        else $error("refresh off period");
    a_refresh_restart: assert property (WORD_WR |=> per_cnt == PERIOD_ZERO && ms_cnt == MS_ZERO)
        else $error("period not restarted by data");
    a_period_keep: assert property (!PERIOD_WR |=> $stable(PERIOD))
        else $error("period changed without a write");

    // data and fallback path
    a_refresh_both: assert property (refresh |=> load_q[0] && load_q[1])
        else $error("refresh missed a channel");
    a_word_apply: assert property (WORD_WR && !COMM_LOST && !WORD_SEL |=> app[0] == $past(WORD_DATA))
        else $error("written word not applied");
    a_lost_word: assert property (WORD_WR && COMM_LOST && !WORD_SEL |=> word[0] == $past(WORD_DATA))
        else $error("word written while lost not kept");
    a_return_apply: assert property (s_comm_back |=> app[0] == $past(word[0]))
        else $error("stored word not applied on return");
    a_fb_range: assert property (FB_WR && !FB_SEL && !FB_VALUE[SIGN_BIT] && FB_VALUE > FULL_SCALE_COUNT
        |=> $stable(fb_val[0]))
        else $error("fallback value above full scale taken");
    a_fb_mode_take: assert property (FB_WR && FB_SEL |=> fb_hold[1] == $past(FB_HOLD))
        else $error("fallback mode not taken");
    a_hold_code: assert property (COMM_LOST && fb_hold[1] && load[1] |=> code[1] == $past(code[1]))
        else $error("hold fallback reloaded another code");

    // status and timing
    a_short_rise: assert property (s_short_up |=> stat[0][ST_SHORT] && stat[1][ST_SHORT] && stat[0][ST_GLOBAL])
        else $error("supply short not reported");
    a_global_quiet: assert property (!short_s2 |=> !stat[0][ST_GLOBAL] && !stat[1][ST_GLOBAL])
        else $error("global bit set without short");
    a_under_err: assert property (aco_count(app[1]) == ZERO_WORD |=> stat[1][ST_UNDER_ERR] && stat[1][ST_UNDER_WARN])
        else $error("under-current error missing");
    a_tick_wrap: assert property (ms_tick |=> ms_cnt == MS_ZERO)
        else $error("millisecond prescaler did not wrap");
    a_count_hold: assert property (!WORD_WR && !ms_tick |=> $stable(per_cnt))
        else $error("period counter moved without a tick");
endmodule : aco_ctrl

// File: logic/aco_pkg.sv
// constants shared by the current-output channel control
package aco_pkg;
    localparam int CHANNELS = 2;
    localparam int WORD_W = 16;
    localparam int CODE_W = 12;
    // word layout: sign at the top, 12 magnitude bits, 3 ignored bits
    localparam int SIGN_BIT = 15;
    localparam int MAG_HI = 14;
    localparam int MAG_LO = 3;
    // analog scaling
    localparam int COUNTS_PER_MA = 1600;
    localparam int FULL_SCALE_MA = 20;
    localparam logic [15:0] FULL_SCALE_COUNT = 16'(FULL_SCALE_MA * COUNTS_PER_MA);
    localparam logic [15:0] OVER_ERR_COUNT = 16'h7ff8;
    localparam logic [15:0] UNDER_WARN_COUNT = 16'h0300;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    // status word bit positions
    localparam int ST_GLOBAL = 0;
    localparam int ST_SHORT = 1;
    localparam int ST_OVER_WARN = 2;
    localparam int ST_OVER_ERR = 3;
    localparam int ST_UNDER_WARN = 4;
    localparam int ST_UNDER_ERR = 5;
    // refresh period limits, milliseconds
    localparam logic [7:0] PERIOD_MIN = 8'h05;
    localparam logic [7:0] PERIOD_ONE = 8'h01;
    localparam logic [7:0] PERIOD_ZERO = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
endpackage : aco_pkg
